// ==== sec_pkg.sv ====
package sec_pkg;
	// array organisation: 4096 x 8 with 32-byte pages
	localparam int ADDR_BITS  = 16;
	localparam int MEM_AW     = 12;
	localparam int MEM_DEPTH  = 4096;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_AW    = 5;
	localparam logic [PAGE_AW-1:0] PAGE_LAST = 5'h1f;

	// instruction codes
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_WRITE      = 8'h02;
	localparam logic [7:0] OP_LATCH_SET  = 8'h06;
	localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
	localparam logic [7:0] OP_STATUS_RD  = 8'h05;
	localparam logic [7:0] OP_STATUS_WR  = 8'h01;

	// status byte field positions
	localparam int ST_BUSY  = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_GPE   = 7;

	// nonvolatile status bits as they stand after reset
	localparam logic [1:0] BP_RST  = 2'h0;
	localparam logic       GPE_RST = 1'b0;

	// self-timed write cycle, longest time rounded down to cycles
	localparam int CLK_PERIOD_NS = 8;
	localparam int TWC_MS        = 6;
	localparam int TWC_CYCLES    = (TWC_MS * 1000000) / CLK_PERIOD_NS;
	localparam int TMR_W         = 20;

	typedef enum logic [2:0] {
		PEND_NONE,
		PEND_LSET,
		PEND_LCLR,
		PEND_SWR,
		PEND_WR
	} sec_pend_e;

	typedef enum logic [2:0] {
		LS_OP,
		LS_ADDR,
		LS_RDATA,
		LS_WDATA,
		LS_SRD,
		LS_SWR,
		LS_TAIL,
		LS_IGNORE
	} sec_lstate_e;

	typedef enum logic [1:0] {
		CS_IDLE,
		CS_PROG,
		CS_WAIT
	} sec_cstate_e;

	// block guard decode: none, upper quarter, upper half, all
	function automatic logic sec_guarded(input logic [MEM_AW-1:0] a, input logic [1:0] bp);
		case (bp)
			2'h1: return (a[MEM_AW-1 -: 2] == 2'h3); // see (RULE24)
			2'h2: return a[MEM_AW-1];
			2'h3: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage

// ==== sec_mem.sv ====
`timescale 1ns/1ps
module sec_mem (
	// read port, link clock
	input  logic                       rd_clk,
	input  logic [sec_pkg::MEM_AW-1:0] rd_addr,
	output logic [7:0]                 rd_data,
	// write port, system clock
	input  logic                       wr_clk,
	input  logic                       wr_en,
	input  logic [sec_pkg::MEM_AW-1:0] wr_addr,
	input  logic [7:0]                 wr_data
);
	logic [7:0] mem_q [sec_pkg::MEM_DEPTH];

	always_ff @(posedge wr_clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// reads are refused while a write runs, so the ports never collide
	always_ff @(posedge rd_clk) begin
		rd_data <= mem_q[rd_addr];
	end
endmodule

// ==== sec_engine.sv ====
`timescale 1ns/1ps
// Overview of operation
// (RULE1) shift instruction byte in on rising clock
// (RULE2) all fields travel most significant bit first
// (RULE3) host keeps select low, pause high throughout
// (RULE4) first bit taken after select falls
// (RULE5) pause freezes sequence, resumes same bit
// (RULE6) decode array read and array write opcodes
// (RULE7) decode latch set and latch clear opcodes
// (RULE8) decode status read and status write opcodes
// (RULE9) read: opcode, 16-bit address, then data
// (RULE10) read address increments and wraps to zero
// (RULE11) raising select ends read, partial byte dropped
// (RULE12) latch sets only on select rising after opcode
// (RULE13) no write without latch set beforehand
// (RULE14) write: opcode, address, up to one page
// (RULE15) write data wraps inside its page
// (RULE16) program only when select rises on byte boundary
// (RULE17) no array access during write cycle
// (RULE18) status readable at any time
// (RULE19) latch clears on reset, clear, status, write
// (RULE20) status bit 0 shows write busy
// (RULE21) status bit 1 shows latch, always updatable
// (RULE22) bits 3,2 block guard; bit 7 pin enable
// (RULE23) select rise starts write cycle, 6 ms max
// (RULE24) block guard codes none, quarter, half, all
// (RULE25) guard pin low and enabled blocks status write
// (RULE26) serial output floats while deselected
// (RULE27) unknown opcode ignored, output floats
// (RULE28) guarded addresses refuse array writes
module sec_engine #(
	parameter int TWC_CYCLES_P = sec_pkg::TWC_CYCLES
) (
	// system clock and reset
	input  logic clk,
	input  logic nrst,
	// serial link
	input  logic sck,
	input  logic cs_n,
	input  logic si,
	input  logic pause_n,
	input  logic guard_n,
	output logic so_o,
	output logic so_oe
);
	localparam logic [sec_pkg::TMR_W-1:0] TWC_LAST = sec_pkg::TMR_W'(TWC_CYCLES_P - 1);

	// per-frame link state, cleared while deselected
	typedef struct packed {
		sec_pkg::sec_lstate_e       st;
		logic [2:0]                 bitn;
		logic                       abyte;
		logic                       is_rd;
		logic [7:0]                 sh;
		logic [sec_pkg::MEM_AW-1:0] raddr;
		logic [7:0]                 tx;
		logic                       ld;
		logic                       out_en;
	} sec_frame_s;

	// link state that must outlive the frame for the commit at select rise
	typedef struct packed {
		sec_pkg::sec_pend_e                        pend;
		logic                                      tog;
		logic [sec_pkg::PAGE_BYTES-1:0][7:0]       pbuf;
		logic [sec_pkg::PAGE_BYTES-1:0]            pmask;
		logic [sec_pkg::MEM_AW-1:0]                wbase;
		logic [sec_pkg::PAGE_AW-1:0]               woff;
		logic [7:0]                                sbyte;
		logic [7:0]                                st_s1;
		logic [7:0]                                st_s2;
	} sec_link_s;

	typedef struct packed {
		logic so;
		logic oe;
	} sec_out_s;

	typedef struct packed {
		logic                        cs_s1;
		logic                        cs_s2;
		logic                        cs_d;
		sec_pkg::sec_pend_e          pend_s1;
		sec_pkg::sec_pend_e          pend_s2;
		logic                        tog_s1;
		logic                        tog_s2;
		logic                        tog_seen;
		logic                        g_s1;
		logic                        g_s2;
		logic                        latch;
		logic                        gpe;
		logic                        busy;
		logic [1:0]                  bp;
		sec_pkg::sec_cstate_e        st;
		logic [sec_pkg::PAGE_AW-1:0] idx;
		logic [sec_pkg::TMR_W-1:0]   tmr;
		logic [7:0]                  status;
	} sec_core_s;

	sec_frame_s                 f_q;
	sec_frame_s                 f_d;
	sec_link_s                  l_q;
	sec_link_s                  l_d;
	sec_out_s                   o_q;
	sec_out_s                   o_d;
	sec_core_s                  c_q;
	sec_core_s                  c_d;
	logic [7:0]                 sh_in;
	logic                       byte_done;
	logic                       busy_l;
	logic [sec_pkg::MEM_AW-1:0] a_full;
	logic [7:0]                 rd_data;
	logic                       mem_we;
	logic [sec_pkg::MEM_AW-1:0] mem_waddr;
	logic [7:0]                 mem_wdata;
	logic                       cs_rise;
	logic                       fresh;
	logic                       lset_now;
	logic [7:0]                 st_w;

	sec_mem u_mem (
		.rd_clk  (sck),
		.rd_addr (f_d.raddr),
		.rd_data (rd_data),
		.wr_clk  (clk),
		.wr_en   (mem_we),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata)
	);

	// ---------------- link side, rising sck ----------------
	always_comb begin
		f_d = f_q;
		l_d = l_q;
		l_d.st_s1 = c_q.status;
		l_d.st_s2 = l_q.st_s1;
		busy_l = l_q.st_s2[sec_pkg::ST_BUSY];
		sh_in = {f_q.sh[6:0], si}; // see (RULE2)
		byte_done = (f_q.bitn == 3'h7);
		a_full = {f_q.raddr[sec_pkg::MEM_AW-1:8], sh_in};
		// shared clocks while deselected or paused must not disturb the frame
		if (pause_n && !cs_n) begin // see (RULE5)
			l_d.pend = sec_pkg::PEND_NONE; // see (RULE16)
			f_d.bitn = f_q.bitn + 3'h1; // see (RULE4)
			f_d.sh = sh_in; // see (RULE1)
			f_d.ld = 1'b0;
			f_d.tx = f_q.ld ? {rd_data[6:0], 1'b0} : {f_q.tx[6:0], 1'b0};
			case (f_q.st)
				sec_pkg::LS_OP: begin
					if (byte_done) begin
						case (sh_in)
							sec_pkg::OP_READ: begin
								f_d.is_rd = 1'b1;
								f_d.st = busy_l ? sec_pkg::LS_IGNORE : sec_pkg::LS_ADDR; // see (RULE17)
							end
							sec_pkg::OP_WRITE: begin
								f_d.is_rd = 1'b0;
								f_d.st = busy_l ? sec_pkg::LS_IGNORE : sec_pkg::LS_ADDR; // see (RULE6)
							end
							sec_pkg::OP_LATCH_SET: begin
								f_d.st = sec_pkg::LS_TAIL;
								l_d.pend = sec_pkg::PEND_LSET; // see (RULE7)
								l_d.tog = ~l_q.tog;
							end
							sec_pkg::OP_LATCH_CLR: begin
								f_d.st = sec_pkg::LS_TAIL;
								l_d.pend = sec_pkg::PEND_LCLR; // see (RULE7)
								l_d.tog = ~l_q.tog;
							end
							sec_pkg::OP_STATUS_RD: begin
								f_d.st = sec_pkg::LS_SRD; // see (RULE8)
								f_d.tx = l_q.st_s2; // see (RULE18)
								f_d.out_en = 1'b1;
							end
							sec_pkg::OP_STATUS_WR: begin
								f_d.st = sec_pkg::LS_SWR; // see (RULE8)
							end
							default: begin
								f_d.st = sec_pkg::LS_IGNORE; // see (RULE27)
							end
						endcase
					end
				end
				sec_pkg::LS_ADDR: begin
					if (byte_done) begin
						f_d.abyte = 1'b1;
						// address bits above the array size are dropped
						f_d.raddr = f_q.abyte ? a_full : {sh_in[sec_pkg::MEM_AW-9:0], 8'h00};
						if (f_q.abyte && f_q.is_rd) begin
							f_d.ld = 1'b1; // see (RULE9)
							f_d.out_en = 1'b1;
							f_d.st = sec_pkg::LS_RDATA;
						end else if (f_q.abyte) begin
							l_d.wbase = a_full; // see (RULE14)
							l_d.woff = a_full[sec_pkg::PAGE_AW-1:0];
							l_d.pmask = '0;
							f_d.st = sec_pkg::LS_WDATA;
						end
					end
				end
				sec_pkg::LS_RDATA: begin
					if (byte_done) begin
						f_d.raddr = f_q.raddr + 1'b1; // see (RULE10)
						f_d.ld = 1'b1;
					end
				end
				sec_pkg::LS_WDATA: begin
					if (byte_done) begin
						l_d.pbuf[l_q.woff] = sh_in;
						l_d.pmask[l_q.woff] = 1'b1;
						l_d.woff = l_q.woff + 1'b1; // see (RULE15)
						l_d.pend = sec_pkg::PEND_WR; // see (RULE16)
						// one toggle per frame, else an even byte count hides the commit
						l_d.tog = l_q.tog ^ (l_q.pmask == '0);
					end
				end
				sec_pkg::LS_SRD: begin
					if (byte_done) begin
						f_d.tx = l_q.st_s2; // see (RULE18)
					end
				end
				sec_pkg::LS_SWR: begin
					if (byte_done) begin
						l_d.sbyte = sh_in;
						l_d.pend = sec_pkg::PEND_SWR;
						l_d.tog = ~l_q.tog;
						f_d.st = sec_pkg::LS_TAIL;
					end
				end
				default: begin
					f_d.st = f_q.st;
				end
			endcase
		end
	end

	// deselect clears the frame at once; a torn byte is simply lost
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			f_q <= '0; // see (RULE11)
		end else begin
			f_q <= f_d;
		end
	end

	always_ff @(posedge sck or negedge nrst) begin
		if (!nrst) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// output changes after the falling edge; floats when deselected or paused
	always_comb begin
		o_d.so = f_q.ld ? rd_data[7] : f_q.tx[7];
		o_d.oe = f_q.out_en && pause_n;
	end

	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			o_q <= '0; // see (RULE26)
		end else begin
			o_q <= o_d;
		end
	end

	assign so_o = o_q.so;
	assign so_oe = o_q.oe;

	// ---------------- core side, clk ----------------
	always_comb begin
		c_d = c_q;
		c_d.cs_s1 = cs_n;
		c_d.cs_s2 = c_q.cs_s1;
		c_d.cs_d = c_q.cs_s2;
		c_d.pend_s1 = l_q.pend;
		c_d.pend_s2 = c_q.pend_s1;
		c_d.tog_s1 = l_q.tog;
		c_d.tog_s2 = c_q.tog_s1;
		c_d.g_s1 = guard_n;
		c_d.g_s2 = c_q.g_s1;
		cs_rise = c_q.cs_s2 && !c_q.cs_d;
		// a frame with no clocks must not replay the previous command
		fresh = (c_q.tog_s2 != c_q.tog_seen);
		lset_now = cs_rise && fresh && (c_q.pend_s2 == sec_pkg::PEND_LSET);
		mem_we = 1'b0;
		mem_waddr = {l_q.wbase[sec_pkg::MEM_AW-1:sec_pkg::PAGE_AW], c_q.idx}; // see (RULE15)
		mem_wdata = l_q.pbuf[c_q.idx];
		case (c_q.st)
			sec_pkg::CS_PROG: begin
				c_d.tmr = c_q.tmr + 1'b1;
				mem_we = l_q.pmask[c_q.idx];
				c_d.idx = c_q.idx + 1'b1;
				if (c_q.idx == sec_pkg::PAGE_LAST) begin
					c_d.st = sec_pkg::CS_WAIT;
				end
			end
			sec_pkg::CS_WAIT: begin
				c_d.tmr = c_q.tmr + 1'b1;
				if (c_q.tmr == TWC_LAST) begin
					c_d.st = sec_pkg::CS_IDLE; // see (RULE23)
					c_d.busy = 1'b0;
					c_d.latch = 1'b0; // see (RULE19)
				end
			end
			default: begin
				c_d.st = sec_pkg::CS_IDLE;
			end
		endcase
		if (cs_rise) begin
			c_d.tog_seen = c_q.tog_s2;
			if (fresh) begin
				case (c_q.pend_s2)
					sec_pkg::PEND_LSET: begin
						c_d.latch = 1'b1; // see (RULE12)
					end
					sec_pkg::PEND_LCLR: begin
						c_d.latch = 1'b0; // see (RULE21)
					end
					sec_pkg::PEND_SWR: begin
						if (!c_q.busy && c_q.latch && !(c_q.gpe && !c_q.g_s2)) begin // see (RULE25)
							c_d.bp = l_q.sbyte[sec_pkg::ST_BP_HI:sec_pkg::ST_BP_LO]; // see (RULE22)
							c_d.gpe = l_q.sbyte[sec_pkg::ST_GPE];
							c_d.busy = 1'b1;
							c_d.tmr = '0;
							c_d.st = sec_pkg::CS_WAIT;
						end
					end
					sec_pkg::PEND_WR: begin
						if (!c_q.busy && c_q.latch // see (RULE13)
								&& !sec_pkg::sec_guarded(l_q.wbase, c_q.bp)) begin // see (RULE28)
							c_d.busy = 1'b1; // see (RULE23)
							c_d.tmr = '0;
							c_d.idx = '0;
							c_d.st = sec_pkg::CS_PROG;
						end
					end
					default: begin
						c_d.latch = c_q.latch;
					end
				endcase
			end
		end
		st_w = '0;
		st_w[sec_pkg::ST_BUSY] = c_d.busy; // see (RULE20)
		st_w[sec_pkg::ST_LATCH] = c_d.latch; // see (RULE21)
		st_w[sec_pkg::ST_BP_HI:sec_pkg::ST_BP_LO] = c_d.bp; // see (RULE24)
		st_w[sec_pkg::ST_GPE] = c_d.gpe; // see (RULE22)
		c_d.status = st_w;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			c_q <= '0; // see (RULE19)
			c_q.cs_s1 <= 1'b1;
			c_q.cs_s2 <= 1'b1;
			c_q.cs_d <= 1'b1;
			c_q.bp <= sec_pkg::BP_RST;
			c_q.gpe <= sec_pkg::GPE_RST;
			c_q.status[sec_pkg::ST_BP_HI:sec_pkg::ST_BP_LO] <= sec_pkg::BP_RST;
			c_q.status[sec_pkg::ST_GPE] <= sec_pkg::GPE_RST;
		end else begin
			c_q <= c_d;
		end
	end

	// ---------------- checks ----------------
	a_busy_on_commit: assert property (@(posedge clk) disable iff (!nrst) // see (RULE23)
		cs_rise && fresh && c_q.pend_s2 == sec_pkg::PEND_WR && !c_q.busy && c_q.latch
		&& !sec_pkg::sec_guarded(l_q.wbase, c_q.bp) |=> c_q.busy && c_q.st == sec_pkg::CS_PROG)
		else $error("write commit did not start the write cycle");
	a_latch_set_edge: assert property (@(posedge clk) disable iff (!nrst) // see (RULE12)
		lset_now |=> c_q.latch ##1 c_q.status[sec_pkg::ST_LATCH])
		else $error("latch not set after select rise");
	a_latch_clear_cmd: assert property (@(posedge clk) disable iff (!nrst) // see (RULE7)
		cs_rise && fresh && c_q.pend_s2 == sec_pkg::PEND_LCLR |=> !c_q.latch)
		else $error("latch not cleared by clear command");
	a_latch_drop_end: assert property (@(posedge clk) disable iff (!nrst) // see (RULE19)
		$fell(c_q.busy) && !$past(lset_now) |-> !c_q.latch)
		else $error("latch survived end of write cycle");
	a_write_needs_latch: assert property (@(posedge clk) disable iff (!nrst) // see (RULE13)
		$rose(c_q.busy) |-> $past(c_q.latch))
		else $error("write cycle began without latch");
	a_busy_bounded: assert property (@(posedge clk) disable iff (!nrst) // see (RULE23)
		c_q.busy |-> c_q.tmr <= TWC_LAST)
		else $error("write cycle ran past its time");
	a_guard_refuse: assert property (@(posedge clk) disable iff (!nrst) // see (RULE25)
		cs_rise && fresh && c_q.pend_s2 == sec_pkg::PEND_SWR && c_q.gpe && !c_q.g_s2
		|=> $stable(c_q.bp) && $stable(c_q.gpe))
		else $error("guarded status write changed status bits");
	a_prot_refuse: assert property (@(posedge clk) disable iff (!nrst) // see (RULE28)
		mem_we |-> !sec_pkg::sec_guarded(mem_waddr, c_q.bp))
		else $error("guarded address programmed");
	a_page_wrap: assert property (@(posedge sck) disable iff (cs_n) // see (RULE15)
		pause_n && f_q.st == sec_pkg::LS_WDATA && byte_done && l_q.woff == sec_pkg::PAGE_LAST
		|=> l_q.woff == '0)
		else $error("write offset left its page");
	a_read_busy_refused: assert property (@(posedge sck) disable iff (cs_n) // see (RULE17)
		pause_n && f_q.st == sec_pkg::LS_OP && byte_done && sh_in == sec_pkg::OP_READ && busy_l
		|=> f_q.st == sec_pkg::LS_IGNORE)
		else $error("read accepted during write cycle");
	a_status_load: assert property (@(posedge sck) disable iff (cs_n) // see (RULE8)
		pause_n && f_q.st == sec_pkg::LS_OP && byte_done && sh_in == sec_pkg::OP_STATUS_RD
		|=> f_q.tx == $past(l_q.st_s2) && f_q.out_en)
		else $error("status byte not loaded for shifting");
	a_pause_hold: assert property (@(posedge sck) disable iff (cs_n) // see (RULE5)
		!pause_n |=> $stable(f_q))
		else $error("frame moved while paused");
	a_unknown_quiet: assert property (@(posedge sck) disable iff (cs_n) // see (RULE27)
		f_q.st == sec_pkg::LS_IGNORE |-> !f_q.out_en)
		else $error("output enabled after unknown opcode");

	c_write_commit: cover property (@(posedge clk) disable iff (!nrst)
		$rose(c_q.busy) && c_q.st == sec_pkg::CS_PROG);
	c_status_commit: cover property (@(posedge clk) disable iff (!nrst)
		$rose(c_q.busy) && c_q.st == sec_pkg::CS_WAIT);
	c_read_wrap: cover property (@(posedge sck) disable iff (cs_n)
		f_q.st == sec_pkg::LS_RDATA && byte_done && f_q.raddr == '1);
	c_pause_mid: cover property (@(posedge sck) disable iff (cs_n)
		!pause_n && f_q.st != sec_pkg::LS_OP);
endmodule

// ==== sec_host.sv ====
`timescale 1ns/1ps
module sec_host (
	// serial link towards the device
	output logic sck,
	output logic cs_n,
	output logic si,
	output logic pause_n,
	input  logic so_o,
	input  logic so_oe
);
	logic [7:0] rxq[$];

	// link clock stands still low between frames
	initial begin
		sck     = 1'b0;
		cs_n    = 1'b1;
		si      = 1'b1;
		pause_n = 1'b1;
	end

	// sends nbits of txq, optional pause just before bit pause_at
	task automatic frame(input logic [7:0] txq[$], input int nbits, input int pause_at);
		logic [7:0] acc;
		int         cnt;
		acc = 8'h00;
		cnt = 0;
		rxq = {};
		cs_n = 1'b0;
		#10;
		for (int i = 0; i < nbits; i++) begin
			if (i == pause_at) begin
				pause_n = 1'b0;
				// clocks during the pause must be ignored
				repeat (2) begin
					si = ~si;
					#16 sck = 1'b1;
					#16 sck = 1'b0;
				end
				#8 pause_n = 1'b1;
			end
			si = txq[i/8][7 - i%8];
			#16 sck = 1'b1;
			if (so_oe === 1'b1) begin
				acc = {acc[6:0], so_o};
				cnt++;
				if (cnt % 8 == 0) begin
					rxq.push_back(acc);
				end
			end
			#16 sck = 1'b0;
		end
		#10 cs_n = 1'b1;
		// released line does not keep its last value
		si = ~si;
		#40;
	endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
	localparam int TWC = 200;

	logic       clk;
	logic       nrst;
	logic       guard_n;
	logic       sck;
	logic       cs_n;
	logic       si;
	logic       pause_n;
	logic       so_o;
	logic       so_oe;
	int         num_errors;
	int         total_checks;
	logic [7:0] st;
	logic [7:0] q[$];

	sec_engine #(.TWC_CYCLES_P(TWC)) sec_engine_i (
		.clk     (clk),
		.nrst    (nrst),
		.sck     (sck),
		.cs_n    (cs_n),
		.si      (si),
		.pause_n (pause_n),
		.guard_n (guard_n),
		.so_o    (so_o),
		.so_oe   (so_oe)
	);

	sec_host sec_host_i (
		.sck     (sck),
		.cs_n    (cs_n),
		.si      (si),
		.pause_n (pause_n),
		.so_o    (so_o),
		.so_oe   (so_oe)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op);
		sec_host_i.frame({op}, 8, -1);
	endtask

	task automatic st_rd(output logic [7:0] s);
		sec_host_i.frame({sec_pkg::OP_STATUS_RD, 8'h00}, 16, -1);
		s = (sec_host_i.rxq.size() > 0) ? sec_host_i.rxq[0] : 8'hxx;
	endtask

	task automatic sw(input logic [7:0] v);
		sec_host_i.frame({sec_pkg::OP_STATUS_WR, v}, 16, -1);
	endtask

	// extra bits past the last byte cancel the write
	task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input int extra);
		logic [7:0] tx[$];
		tx = {sec_pkg::OP_WRITE, a[15:8], a[7:0]};
		tx = {tx, d, 8'h00};
		sec_host_i.frame(tx, 24 + 8 * d.size() + extra, -1);
	endtask

	// three stray bits after the last byte check the partial byte is dropped
	task automatic rd(input logic [15:0] a, input int n, input int pz, output logic [7:0] r[$]);
		logic [7:0] tx[$];
		tx = {sec_pkg::OP_READ, a[15:8], a[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
		sec_host_i.frame(tx, 24 + 8 * n + 3, pz);
		r = sec_host_i.rxq;
		check({7'h00, so_oe}, 8'h00);
	endtask

	task automatic idle();
		logic [7:0] s;
		int         n;
		s = 8'h01;
		n = 0;
		while (s[0] !== 1'b0 && n < 40) begin
			st_rd(s);
			n++;
		end
		check(s & 8'h01, 8'h00);
	endtask

	initial begin
		#500000;
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end

	initial begin
		num_errors = 0;
		total_checks = 0;
		nrst = 1'b0;
		guard_n = 1'b1;
		repeat (6) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
		check({7'h00, so_oe}, 8'h00);
		st_rd(st);
		check(st, 8'h00);
		cmd(sec_pkg::OP_LATCH_SET);
		st_rd(st);
		check(st, 8'h02);
		cmd(sec_pkg::OP_LATCH_CLR);
		st_rd(st);
		check(st, 8'h00);
		sec_host_i.frame({sec_pkg::OP_LATCH_SET, sec_pkg::OP_WRITE, 8'h00, 8'h10, 8'h55}, 40, -1);
		st_rd(st);
		check(st, 8'h00);
		// page write running past the page end
		cmd(sec_pkg::OP_LATCH_SET);
		wr(16'h001e, {8'ha1, 8'hb2, 8'hc3}, 0);
		st_rd(st);
		check(st, 8'h03);
		rd(16'h0000, 1, -1, q);
		check(8'(q.size()), 8'h00);
		idle();
		st_rd(st);
		check(st, 8'h00);
		rd(16'h001e, 2, -1, q);
		check(8'(q.size()), 8'h02);
		check(q[0], 8'ha1);
		check(q[1], 8'hb2);
		rd(16'h0000, 1, 13, q);
		check(q[0], 8'hc3);
		// sequential read wraps from the top address to zero
		cmd(sec_pkg::OP_LATCH_SET);
		wr(16'h0fff, {8'h5a}, 0);
		idle();
		rd(16'h0fff, 2, -1, q);
		check(q[0], 8'h5a);
		check(q[1], 8'hc3);
		// select rising mid-byte aborts the write
		cmd(sec_pkg::OP_LATCH_SET);
		wr(16'h0000, {8'h77}, 3);
		st_rd(st);
		check(st, 8'h02);
		rd(16'h0000, 1, -1, q);
		check(q[0], 8'hc3);
		sec_host_i.frame({8'hff, 8'h00, 8'h00}, 24, -1);
		check(8'(sec_host_i.rxq.size()), 8'h00);
		sw(8'h8c);
		idle();
		st_rd(st);
		check(st, 8'h8c);
		cmd(sec_pkg::OP_LATCH_SET);
		wr(16'h0000, {8'h11}, 0);
		st_rd(st);
		check(st, 8'h8e);
		@(posedge clk);
		#1 guard_n = 1'b0;
		sw(8'h04);
		st_rd(st);
		check(st, 8'h8e);
		@(posedge clk);
		#1 guard_n = 1'b1;
		sw(8'h04);
		idle();
		st_rd(st);
		check(st, 8'h04);
		// upper quarter guarded, just below it writable
		cmd(sec_pkg::OP_LATCH_SET);
		wr(16'h0c00, {8'h22}, 0);
		st_rd(st);
		check(st, 8'h06);
		// two bytes in one frame must still commit
		wr(16'h0bfe, {8'h44, 8'h33}, 0);
		idle();
		rd(16'h0bfe, 2, -1, q);
		check(q[0], 8'h44);
		check(q[1], 8'h33);
		conclude();
	end
endmodule
